// File: hdl/wsp_pkg.sv
// constants, types and register map of the wake and sleep power control block
package wsp_pkg;
  // clock rate and timing figures
  localparam int unsigned CLK_HZ = 20000000; // system clock in hz
  localparam int unsigned SLEEP_REL_US = 10000; // sleep release delay, 10 ms
  localparam int unsigned WAKE_LOW_US = 1000; // wake-low qualification, 1.0 ms
  localparam int unsigned SLEEP_REL_CYC = (SLEEP_REL_US * (CLK_HZ / 1000000)); // delay cycles
  localparam int unsigned WAKE_LOW_CYC = (WAKE_LOW_US * (CLK_HZ / 1000000)); // low cycles
  localparam int CNT_W = 18; // counter width, holds 200000

  // synchroniser lanes
  localparam int SY_WAKE = 0; // battery wake level
  localparam int SY_UV = 1; // battery above step-up undervoltage level
  localparam int SY_SUG = 2; // step-up good
  localparam int SY_SDG = 3; // step_down_good
  localparam int SY_IRST = 4; // internal reset
  localparam int SY_W = 5; // lane count

  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00; // converter-off command
  localparam logic [7:0] ADR_STAT = 8'h04; // live status, ignition_status_word
  localparam logic [7:0] ADR_IRQ = 8'h08; // sticky events, write one to clear
  localparam logic [7:0] ADR_MASK = 8'h0c; // event mask

  // ctrl fields
  localparam int CTRL_OFF = 0; // converter-off command latch
  // status fields
  localparam int ST_IGN = 0; // ignition_flag
  localparam int ST_SLEEP_N = 1; // sleep state, active low sleep
  localparam int ST_SLP_RST = 2; // sleep release reset
  localparam int ST_SUG = 3; // step-up good
  localparam int ST_SDG = 4; // step_down_good
  localparam int ST_LOCK = 5; // 5 v rail restart lockout
  localparam int ST_SEL = 6; // pre-driver select, two bits
  // event fields
  localparam int EV_WAKE = 0; // sleep release reset released
  localparam int EV_OFF = 1; // latched off command executed
  localparam int EV_LOCK = 2; // rail lockout taken
  localparam int EV_W = 3; // event count

  // pre-driver source positions
  localparam logic [1:0] SEL_RST = 2'h0; // internal reset position
  localparam logic [1:0] SEL_BAT = 2'h1; // battery supply
  localparam logic [1:0] SEL_BST = 2'h2; // step-up output

  // power mode states
  typedef enum logic [1:0] {
    PM_SLEEP = 2'b00,
    PM_DELAY = 2'b01,
    PM_RUN = 2'b10,
    PM_OFFP = 2'b11
  } wsp_pm_t;

  // whole block state
  typedef struct packed {
    logic [SY_W-1:0] s1; // first sync stage
    logic [SY_W-1:0] s2; // second sync stage
    wsp_pm_t pm; // power mode
    logic [CNT_W-1:0] cnt; // delay counter
    logic off_cmd; // latched converter-off command
    logic lock; // rail restart lockout
    logic conv_en; // converters running
    logic rail_en; // 5 v rail enable
    logic sleep_n; // sleep state, low while asleep
    logic [1:0] sel; // pre-driver select
    logic [EV_W-1:0] irq; // sticky events
    logic [EV_W-1:0] mask; // event mask
    logic irq_out; // interrupt line
    logic ack; // bus acknowledge
    logic [31:0] dat; // bus read data
  } wsp_st_t;
endpackage

// File: hdl/wsp_power_ctl.sv
// wake, sleep and supply sequencing logic with a wishbone register slave
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module wsp_power_ctl #(
  parameter int unsigned SLEEP_REL_CYC = wsp_pkg::SLEEP_REL_CYC, // 10 ms in cycles
  parameter int unsigned WAKE_LOW_CYC = wsp_pkg::WAKE_LOW_CYC // 1.0 ms in cycles
) (
  input wire logic clk_i, // 20 mhz clock
  input wire logic rst_i, // synchronous reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic wake_i, // battery wake comparator
  input wire logic batt_above_uv_i, // battery_supply_pin above step_up_undervoltage_level
  input wire logic step_up_good_i, // step_up_output at normal level
  input wire logic step_down_good_i, // step_down_good comparator
  input wire logic int_reset_i, // internal reset, also restores pre-driver select
  output logic conv_en_o, // start step-up and step-down converters
  output logic rail5_en_o, // 5 v main rail enable
  output logic sleep_n_o, // sleep state, low while asleep
  output logic sleep_rst_o, // sleep release reset
  output logic [1:0] predrv_sel_o, // pre-driver source position
  output logic irq_o // level interrupt
);
  wsp_pkg::wsp_st_t r; // registered state
  wsp_pkg::wsp_st_t n; // next state
  logic wake; // synced wake
  logic uv_ok; // synced battery comparison
  logic sug; // synced step-up good
  logic sdg; // synced step_down_good
  logic irst; // synced internal reset
  logic wr; // write taken this cycle
  logic [wsp_pkg::EV_W-1:0] ev; // events this cycle
  logic [31:0] stat_w; // status word

  // only the second stage is read
  assign wake = r.s2[wsp_pkg::SY_WAKE];
  assign uv_ok = r.s2[wsp_pkg::SY_UV];
  assign sug = r.s2[wsp_pkg::SY_SUG];
  assign sdg = r.s2[wsp_pkg::SY_SDG];
  assign irst = r.s2[wsp_pkg::SY_IRST];

  // status word assembly
  always_comb begin
    stat_w = 32'h0;
    stat_w[wsp_pkg::ST_IGN] = uv_ok;
    stat_w[wsp_pkg::ST_SLEEP_N] = r.sleep_n;
    stat_w[wsp_pkg::ST_SLP_RST] = ~r.sleep_n;
    stat_w[wsp_pkg::ST_SUG] = sug;
    stat_w[wsp_pkg::ST_SDG] = sdg;
    stat_w[wsp_pkg::ST_LOCK] = r.lock;
    stat_w[wsp_pkg::ST_SEL +: 2] = r.sel;
  end

  // next-state logic for the whole block
  always_comb begin
    n = r;
    ev = '0;
    // pin synchronisers
    n.s1 = {int_reset_i, step_down_good_i, step_up_good_i, batt_above_uv_i, wake_i};
    n.s2 = r.s1;
    // bus answer one cycle after the request
    n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
    wr = n.ack & wb_we_i;
    // power mode sequencing
    case (r.pm)
      wsp_pkg::PM_SLEEP: begin
        n.cnt = '0;
        if (wake) begin
          n.pm = wsp_pkg::PM_DELAY;
        end
      end
      wsp_pkg::PM_DELAY: begin
        if (!wake) begin
          n.pm = wsp_pkg::PM_SLEEP;
          n.cnt = '0;
        end else if (r.cnt == wsp_pkg::CNT_W'(SLEEP_REL_CYC - 1)) begin
          n.pm = wsp_pkg::PM_RUN;
          n.cnt = '0;
          ev[wsp_pkg::EV_WAKE] = 1'b1;
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      wsp_pkg::PM_RUN: begin
        n.cnt = '0;
        if (r.off_cmd && !wake) begin
          n.pm = wsp_pkg::PM_OFFP;
        end
      end
      wsp_pkg::PM_OFFP: begin
        if (wake) begin
          n.pm = wsp_pkg::PM_RUN;
          n.cnt = '0;
        end else if (r.cnt == wsp_pkg::CNT_W'(WAKE_LOW_CYC - 1)) begin
          n.pm = wsp_pkg::PM_SLEEP;
          n.cnt = '0;
          n.off_cmd = 1'b0;
          ev[wsp_pkg::EV_OFF] = 1'b1;
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      default: begin
        n.pm = wsp_pkg::PM_SLEEP;
      end
    endcase
    // command latch, never acted on at once
    if (wr && wb_adr_i == wsp_pkg::ADR_CTRL && wb_sel_i[0] && wb_dat_i[wsp_pkg::CTRL_OFF]) begin
      n.off_cmd = 1'b1;
    end
    // sleep state, low until release reset ends
    n.sleep_n = (n.pm == wsp_pkg::PM_RUN) || (n.pm == wsp_pkg::PM_OFFP);
    // converters: battery above lockout and either wake or awake
    n.conv_en = uv_ok & (wake | n.sleep_n);
    // lockout when the rail loses step_down_good, released by internal reset
    if (irst) begin
      n.lock = 1'b0;
    end else if (r.rail_en && !sdg) begin
      n.lock = 1'b1;
      ev[wsp_pkg::EV_LOCK] = 1'b1;
    end
    n.rail_en = n.sleep_n & sdg & ~n.lock & ~irst;
    // pre-driver source table
    if (irst) begin
      n.sel = wsp_pkg::SEL_RST;
    end else if (!r.sleep_n || !sug) begin
      n.sel = wsp_pkg::SEL_BAT;
    end else begin
      n.sel = wsp_pkg::SEL_BST;
    end
    // sticky events, set wins over write-one clear
    n.irq = r.irq;
    if (wr && wb_adr_i == wsp_pkg::ADR_IRQ && wb_sel_i[0]) begin
      n.irq = r.irq & ~wb_dat_i[wsp_pkg::EV_W-1:0];
    end
    n.irq = n.irq | ev;
    if (wr && wb_adr_i == wsp_pkg::ADR_MASK && wb_sel_i[0]) begin
      n.mask = wb_dat_i[wsp_pkg::EV_W-1:0];
    end
    n.irq_out = |(n.irq & n.mask);
    // read data, unmapped reads zero
    n.dat = 32'h0;
    if (wb_adr_i == wsp_pkg::ADR_CTRL) begin
      n.dat[wsp_pkg::CTRL_OFF] = r.off_cmd;
    end else if (wb_adr_i == wsp_pkg::ADR_STAT) begin
      n.dat = stat_w;
    end else if (wb_adr_i == wsp_pkg::ADR_IRQ) begin
      n.dat[wsp_pkg::EV_W-1:0] = r.irq;
    end else if (wb_adr_i == wsp_pkg::ADR_MASK) begin
      n.dat[wsp_pkg::EV_W-1:0] = r.mask;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign conv_en_o = r.conv_en;
  assign rail5_en_o = r.rail_en;
  assign sleep_n_o = r.sleep_n;
  assign sleep_rst_o = ~r.sleep_n;
  assign predrv_sel_o = r.sel;
  assign irq_o = r.irq_out;

  // reset position follows internal reset
  property p_sel_rst;
    @(posedge clk_i) disable iff (rst_i) irst |=> (predrv_sel_o == wsp_pkg::SEL_RST);
  endproperty
  a_sel_rst: assert property (p_sel_rst) else $error("preselect not 0 in reset");

  // step-up source when awake with step-up good
  property p_sel_bst;
    @(posedge clk_i) disable iff (rst_i)
      (!irst && r.sleep_n && sug) |=> (predrv_sel_o == wsp_pkg::SEL_BST);
  endproperty
  a_sel_bst: assert property (p_sel_bst) else $error("preselect not 2");

  // rail never on without step_down_good
  property p_rail_sdg;
    @(posedge clk_i) disable iff (rst_i) rail5_en_o |-> $past(sdg);
  endproperty
  a_rail_sdg: assert property (p_rail_sdg) else $error("rail on without step down good");

  // lockout holds rail off until internal reset
  property p_lock;
    @(posedge clk_i) disable iff (rst_i) (r.lock && !irst) |=> !rail5_en_o;
  endproperty
  a_lock: assert property (p_lock) else $error("rail restarted under lockout");

  // converters start one edge after synced wake with battery good
  property p_conv;
    @(posedge clk_i) disable iff (rst_i) (wake && uv_ok) |=> conv_en_o;
  endproperty
  a_conv: assert property (p_conv) else $error("converters not started");

  // sleep release reset covers the whole delay
  property p_delay;
    @(posedge clk_i) disable iff (rst_i) (r.pm == wsp_pkg::PM_DELAY) |-> sleep_rst_o;
  endproperty
  a_delay: assert property (p_delay) else $error("sleep reset released early");

  // wake returning cancels the pending shutdown
  property p_cancel;
    @(posedge clk_i) disable iff (rst_i)
      (r.pm == wsp_pkg::PM_OFFP && wake) |=> (r.pm == wsp_pkg::PM_RUN && r.cnt == '0);
  endproperty
  a_cancel: assert property (p_cancel) else $error("off not cancelled");

  // qualified low executes the command
  property p_exec;
    @(posedge clk_i) disable iff (rst_i)
      (r.pm == wsp_pkg::PM_OFFP && !wake && r.cnt == wsp_pkg::CNT_W'(WAKE_LOW_CYC - 1))
      |=> (!sleep_n_o && !r.off_cmd);
  endproperty
  a_exec: assert property (p_exec) else $error("off not executed");

  // command never acts while wake is high
  property p_hold;
    @(posedge clk_i) disable iff (rst_i) (r.pm == wsp_pkg::PM_RUN && wake) |=> sleep_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("off acted while wake high");

  // status read shows ignition comparison
  property p_ign;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == wsp_pkg::ADR_STAT)
      |=> (wb_ack_o && wb_dat_o[wsp_pkg::ST_IGN] == $past(uv_ok));
  endproperty
  a_ign: assert property (p_ign) else $error("ignition flag wrong");

  // wake seen while asleep starts the release delay
  property p_wake_delay;
    @(posedge clk_i) disable iff (rst_i)
      (r.pm == wsp_pkg::PM_SLEEP && wake) |=> (r.pm == wsp_pkg::PM_DELAY && sleep_rst_o);
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("delay not started");

  // wake dropping during the delay restarts it from zero
  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
      (r.pm == wsp_pkg::PM_DELAY && !wake) |=> (r.pm == wsp_pkg::PM_SLEEP && r.cnt == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted");

  // end of the delay releases sleep reset and flags the event
  property p_release;
    @(posedge clk_i) disable iff (rst_i)
      (r.pm == wsp_pkg::PM_DELAY && wake && r.cnt == wsp_pkg::CNT_W'(SLEEP_REL_CYC - 1))
      |=> (sleep_n_o && r.irq[wsp_pkg::EV_WAKE]);
  endproperty
  a_release: assert property (p_release) else $error("sleep reset not released");

  // without a latched command the system stays awake
  property p_off_wait;
    @(posedge clk_i) disable iff (rst_i) (r.pm == wsp_pkg::PM_RUN && !r.off_cmd) |=> sleep_n_o;
  endproperty
  a_off_wait: assert property (p_off_wait) else $error("shutdown without command");

  // sleep state keeps the rail off
  property p_gate;
    @(posedge clk_i) disable iff (rst_i) !sleep_n_o |-> !rail5_en_o;
  endproperty
  a_gate: assert property (p_gate) else $error("rail on while asleep");

  // losing step_down_good with the rail up takes the lockout
  property p_lock_set;
    @(posedge clk_i) disable iff (rst_i)
      (rail5_en_o && !sdg && !irst) |=> (r.lock && !rail5_en_o);
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lockout not taken");

  // battery position while asleep or step-up not good
  property p_sel_bat;
    @(posedge clk_i) disable iff (rst_i)
      (!irst && (!r.sleep_n || !sug)) |=> (predrv_sel_o == wsp_pkg::SEL_BAT);
  endproperty
  a_sel_bat: assert property (p_sel_bat) else $error("preselect not 1");
endmodule

`default_nettype wire

// File: sim/wsp_host_model.sv
// host model: wishbone master issuing power commands
`timescale 1ns/1ps
`default_nettype none
module wsp_host_model (
  input wire logic clk_i, // bus clock
  input wire logic [31:0] dat_i, // read data
  input wire logic ack_i, // acknowledge
  output logic cyc_o, // cycle
  output logic stb_o, // strobe
  output logic we_o, // write
  output logic [3:0] sel_o, // byte lanes
  output logic [7:0] adr_o, // byte address
  output logic [31:0] dat_o // write data
);
  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    sel_o = 4'h0;
    adr_o = 8'h00;
    dat_o = 32'h00000000;
  end
  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    sel_o <= 4'hf;
    adr_o <= a;
    dat_o <= d;
    // no local limit, the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    // released data shows the inverse, never the old value
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    sel_o <= 4'h0;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// File: sim/test_wake_sleep_power_control.sv
// self-checking bench for the wake and sleep power control
`timescale 1ns/1ps
`default_nettype none
module test_wake_sleep_power_control;
  logic clk_i = 1'b0; // 20 mhz clock
  logic rst_i = 1'b1; // synchronous reset
  logic wake = 1'b0, uv = 1'b1, sug = 1'b0, sdg = 1'b0, irst = 1'b0; // pin levels
  logic cyc, stb, we, ack, conv, rail, slp_n, slp_rst, irq; // bus and outputs
  logic [7:0] adr; // bus address
  logic [3:0] sel; // byte lanes
  logic [31:0] wdat, rdat; // bus data
  logic [1:0] psel; // pre-driver position
  int fails = 0; // mismatches
  int checks_done = 0; // comparisons
  // half period of 25 ns
  always #25 clk_i = ~clk_i;
  wsp_host_model host (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
  wsp_power_ctl #(.SLEEP_REL_CYC(20), .WAKE_LOW_CYC(8)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wake_i(wake), .batt_above_uv_i(uv), .step_up_good_i(sug),
    .step_down_good_i(sdg), .int_reset_i(irst), .conv_en_o(conv),
    .rail5_en_o(rail), .sleep_n_o(slp_n), .sleep_rst_o(slp_rst),
    .predrv_sel_o(psel), .irq_o(irq));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  // read and compare the masked bits
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h00000000, q);
    chk(nm, e, q & m);
  endtask
  task automatic t_reset();
    cyc_wait(10);
    chk("sleep_rst", 32'h1, slp_rst);
    rst_i <= 1'b0;
    rd("mask", 8'h0c, 32'h0, 32'hffffffff);
    rd("unmapped", 8'h10, 32'h0, 32'hffffffff);
    $display("test reset done");
  endtask
  // wake, restart of the delay, release and interrupt
  task automatic t_wake();
    wr(8'h0c, 32'h1);
    wake <= 1'b1;
    cyc_wait(6);
    chk("conv_en", 32'h1, conv);
    chk("held", 32'h1, slp_rst);
    wake <= 1'b0;
    cyc_wait(6);
    wake <= 1'b1;
    cyc_wait(18);
    chk("restart", 32'h1, slp_rst);
    cyc_wait(10);
    chk("released", 32'h0, slp_rst);
    chk("irq_line", 32'h1, irq);
    rd("status", 8'h04, 32'h43, 32'hff);
    rd("wake_evt", 8'h08, 32'h1, 32'h7);
    wr(8'h08, 32'h1);
    cyc_wait(3);
    chk("irq_clr", 32'h0, irq);
    $display("test wake done");
  endtask
  // rail gating and clamp lockout
  task automatic t_rail();
    sdg <= 1'b1;
    sug <= 1'b1;
    cyc_wait(6);
    chk("rail_on", 32'h1, rail);
    chk("sel_boost", 32'h2, psel);
    sdg <= 1'b0;
    cyc_wait(6);
    chk("rail_off", 32'h0, rail);
    sdg <= 1'b1;
    cyc_wait(6);
    chk("rail_lock", 32'h0, rail);
    chk("irq_masked", 32'h0, irq);
    rd("lock_stat", 8'h04, 32'hbb, 32'hff);
    rd("lock_evt", 8'h08, 32'h4, 32'h4);
    $display("test rail done");
  endtask
  // latched off command, short glitch, qualified low
  task automatic t_off();
    wr(8'h00, 32'h1);
    cyc_wait(30);
    chk("latched", 32'h1, slp_n);
    rd("ctrl", 8'h00, 32'h1, 32'h1);
    wake <= 1'b0;
    cyc_wait(4);
    wake <= 1'b1;
    cyc_wait(20);
    chk("glitch", 32'h1, slp_n);
    wake <= 1'b0;
    cyc_wait(6);
    chk("early", 32'h1, slp_n);
    cyc_wait(10);
    chk("shutdown", 32'h0, slp_n);
    chk("conv_off", 32'h0, conv);
    chk("rst_back", 32'h1, slp_rst);
    rd("off_evt", 8'h08, 32'h2, 32'h2);
    $display("test off done");
  endtask
  // internal reset: selector and lockout release
  task automatic t_irst();
    rd("lock_kept", 8'h04, 32'h20, 32'h20);
    irst <= 1'b1;
    cyc_wait(6);
    chk("sel_irst", 32'h0, psel);
    irst <= 1'b0;
    cyc_wait(6);
    chk("sel_sleep", 32'h1, psel);
    rd("lock_clr", 8'h04, 32'h0, 32'h20);
    $display("test internal reset done");
  endtask
  // counts, verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    t_reset();
    t_wake();
    t_rail();
    t_off();
    t_irst();
    tally_and_finish();
  end
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    cyc_wait(3000);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
